/* File: hdl/velocity_setpoint_override.sv */
/*
 velocity setpoint and override block for a trajectory generator with
 NUM_AXES axes. software loads setpoints and overrides over apb; a tick
 command advances every axis by one trajectory sample period.
 assumes an apb master with 32-bit data on core_clk_i, synchronous reset.
*/
// The register offsets and the APB slave port were left to the implementer.
// How it works
// - setpoints held 16.16, accel per period squared
// - velocity resolution is one sixteen-bit fraction
// - loaded velocity shadowed until start or blend
// - active velocity persists across later moves
// - velocity mode direction follows setpoint sign
// - vector velocity copied to each member axis
// - override scales velocity zero to 150 percent
// - override acts immediately, never buffered
// - override changes ramp with accel, decel, s-curve
// - override applies except on contoured moves and geared slaves
// - vector override copied to each member axis
// - geared slave follows master scaled velocity
// - override persists until next override load
// - reset sets every override to 100 percent
// - zero override decelerates to hold
// - override integer 0 to 384, no float
// - unequal overrides in a vector accepted
// - source selector codes immediate, variable, indirect
`timescale 1ns/1ps
module velocity_setpoint_override (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // trajectory outputs, one 16.16 word and one direction bit per axis
   output logic [vso_pkg::NUM_AXES*32-1:0] cur_vel_o,
   output logic [vso_pkg::NUM_AXES-1:0] dir_o
);
   typedef struct packed {
      vso_pkg::axis_s [vso_pkg::NUM_AXES-1:0] ax;
      logic [vso_pkg::AX_W-1:0] target;
      logic target_vector;
      logic [7:0] ctrl;
      logic [7:0] src;
      logic src_err;
      vso_pkg::apb_rsp_s rsp;
      logic [vso_pkg::NUM_AXES*32-1:0] vel_out;
      logic [vso_pkg::NUM_AXES-1:0] dir;
   } state_s;

   state_s st;
   state_s next_st;

   // selector decode, used by the write check and the status read
   function automatic logic [1:0] src_kind(input logic [7:0] code);
      if (code == vso_pkg::SRC_IMMEDIATE) begin
         return vso_pkg::SRC_KIND_IMM;
      end else if (code >= vso_pkg::SRC_VAR_LO && code <= vso_pkg::SRC_VAR_HI) begin
         return vso_pkg::SRC_KIND_VAR;
      end else if (code >= vso_pkg::SRC_IND_LO && code <= vso_pkg::SRC_IND_HI) begin
         return vso_pkg::SRC_KIND_IND;
      end else begin
         return vso_pkg::SRC_KIND_BAD;
      end
   endfunction

   // setpoint times override over 256, magnitude truncated, sign kept
   function automatic logic [31:0] scale(input logic [31:0] v, input logic [8:0] o);
      logic [31:0] mag;
      logic [40:0] prod;
      logic [31:0] res;
      mag = v[31] ? 32'(-v) : v;
      prod = mag * o;
      res = prod[39:8];
      return v[31] ? 32'(-res) : res;
   endfunction

   // one-step ramp of cur toward goal, limited by accel or decel
   function automatic logic [31:0] ramp(input logic [31:0] cur, input logic [31:0] goal,
                                        input logic [31:0] acc, input logic [31:0] dec);
      logic signed [32:0] diff;
      logic signed [32:0] step;
      logic speeding;
      diff = $signed({goal[31], goal}) - $signed({cur[31], cur});
      // accel only when goal and cur share a sign and magnitude grows, else decel
      speeding = (goal[31] == cur[31]) && ((goal[31] ? -diff : diff) > 0);
      step = $signed({1'b0, speeding ? acc : dec});
      if (diff > step) begin
         return 32'(cur + step[31:0]);
      end else if (diff < -step) begin
         return 32'(cur - step[31:0]);
      end else begin
         return goal;
      end
   endfunction

   logic wr;
   logic rd;
   assign wr = psel_i && penable_i && pwrite_i && !st.rsp.pready;
   assign rd = psel_i && penable_i && !pwrite_i && !st.rsp.pready;

   always_comb begin
      logic [31:0] rdata;
      logic err;
      logic tick;
      logic [31:0] goal;
      logic [31:0] base;
      logic [vso_pkg::AX_W-1:0] m;
      rdata = 32'h0000_0000;
      err = 1'b0;
      tick = 1'b0;
      goal = 32'h0000_0000;
      base = 32'h0000_0000;
      m = '0;
      next_st = st;
      next_st.rsp.pready = 1'b0;
      next_st.rsp.pslverr = 1'b0;
      if (wr) begin
         case (paddr_i)
            vso_pkg::OFF_VEL: begin
               // vector target loads every member shadow with the same word
               for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
                  if ((st.target_vector && st.ax[i].vector_member) ||
                      (!st.target_vector && st.target == i[vso_pkg::AX_W-1:0])) begin
                     next_st.ax[i].vel_shadow = pwdata_i;
                  end
               end
            end
            vso_pkg::OFF_ACC: next_st.ax[st.target].acc = pwdata_i;
            vso_pkg::OFF_DEC: next_st.ax[st.target].dec = pwdata_i;
            vso_pkg::OFF_SCURVE: next_st.ax[st.target].scurve = pwdata_i[15:0];
            vso_pkg::OFF_OVR: begin
               if (pwdata_i > {23'h0, vso_pkg::OVR_MAX}) begin
                  err = 1'b1;
               end else begin
                  for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
                     // no equality check among members: mixed overrides allowed
                     if ((st.target_vector && st.ax[i].vector_member) ||
                         (!st.target_vector && st.target == i[vso_pkg::AX_W-1:0])) begin
                        next_st.ax[i].ovr = pwdata_i[8:0];
                     end
                  end
               end
            end
            vso_pkg::OFF_TARGET: begin
               next_st.target = pwdata_i[vso_pkg::AX_W-1:0];
               next_st.target_vector = pwdata_i[vso_pkg::TGT_VECTOR_BIT];
               if (!pwdata_i[vso_pkg::TGT_VECTOR_BIT]) begin
                  next_st.ax[pwdata_i[vso_pkg::AX_W-1:0]].vector_member =
                     pwdata_i[vso_pkg::TGT_VECTOR_BIT+1];
               end
            end
            vso_pkg::OFF_CTRL: next_st.ctrl = pwdata_i[7:0];
            vso_pkg::OFF_CMD: begin
               for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
                  if (pwdata_i[vso_pkg::CMD_START_BIT] || pwdata_i[vso_pkg::CMD_BLEND_BIT]) begin
                     next_st.ax[i].vel_active = st.ax[i].vel_shadow;
                  end
               end
               tick = pwdata_i[vso_pkg::CMD_TICK_BIT];
            end
            vso_pkg::OFF_SRC: begin
               next_st.src = pwdata_i[7:0];
               next_st.src_err = (src_kind(pwdata_i[7:0]) == vso_pkg::SRC_KIND_BAD);
            end
            default: err = 1'b1;
         endcase
      end
      if (rd) begin
         case (paddr_i)
            vso_pkg::OFF_VEL: rdata = st.ax[st.target].vel_shadow;
            vso_pkg::OFF_ACC: rdata = st.ax[st.target].acc;
            vso_pkg::OFF_DEC: rdata = st.ax[st.target].dec;
            vso_pkg::OFF_SCURVE: rdata = {16'h0000, st.ax[st.target].scurve};
            vso_pkg::OFF_OVR: rdata = {23'h0, st.ax[st.target].ovr};
            vso_pkg::OFF_TARGET: rdata = {22'h0, st.ax[st.target].vector_member,
                                          st.target_vector, 6'h0, st.target};
            vso_pkg::OFF_CTRL: rdata = {24'h0, st.ctrl};
            vso_pkg::OFF_SRC: rdata = {24'h0, st.src};
            vso_pkg::OFF_ACT_VEL: rdata = st.ax[st.target].vel_active;
            vso_pkg::OFF_CUR_VEL: rdata = st.ax[st.target].cur_vel;
            vso_pkg::OFF_STATUS: rdata = {29'h0, st.src_err, src_kind(st.src)};
            vso_pkg::OFF_CMD: rdata = 32'h0000_0000;
            default: err = 1'b1;
         endcase
      end
      if (wr || rd) begin
         next_st.rsp.pready = 1'b1;
         next_st.rsp.pslverr = err;
         next_st.rsp.prdata = rdata;
      end
      // one trajectory sample period per tick
      if (tick) begin
         for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
            m = st.ctrl[vso_pkg::CTRL_GEAR_MASTER_LSB +: vso_pkg::AX_W];
            if (st.ctrl[vso_pkg::CTRL_GEAR_BIT] && i[vso_pkg::AX_W-1:0] != m) begin
               goal = st.ax[m].cur_vel;
            end else if (st.ctrl[vso_pkg::CTRL_CONTOUR_BIT]) begin
               goal = st.ax[i].vel_active;
            end else begin
               goal = scale(st.ax[i].vel_active, st.ax[i].ovr);
            end
            // s-curve: hold off each change for scurve-1 periods, stepping once every scurve periods, to soften jerk
            if (st.ax[i].s_cnt + 16'h0001 < st.ax[i].scurve && goal != st.ax[i].cur_vel) begin
               next_st.ax[i].s_cnt = 16'(st.ax[i].s_cnt + 16'h0001);
            end else begin
               next_st.ax[i].s_cnt = 16'h0000;
               base = ramp(st.ax[i].cur_vel, goal, st.ax[i].acc, st.ax[i].dec);
               next_st.ax[i].cur_vel = base;
            end
         end
      end
      for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
         next_st.vel_out[i*32 +: 32] = next_st.ax[i].cur_vel;
         // reverse on negative setpoint in velocity mode, else on negative current velocity
         next_st.dir[i] = st.ctrl[vso_pkg::CTRL_VELMODE_BIT] ?
                          next_st.ax[i].vel_active[31] : next_st.ax[i].cur_vel[31];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         for (int i = 0; i < vso_pkg::NUM_AXES; i++) begin
            st.ax[i].vel_shadow <= vso_pkg::VEL_RESET;
            st.ax[i].vel_active <= vso_pkg::VEL_RESET;
            st.ax[i].acc <= vso_pkg::ACC_RESET;
            st.ax[i].dec <= vso_pkg::ACC_RESET;
            st.ax[i].scurve <= vso_pkg::SCURVE_RESET;
            st.ax[i].s_cnt <= 16'h0000;
            st.ax[i].ovr <= vso_pkg::OVR_NEUTRAL;
            st.ax[i].cur_vel <= vso_pkg::VEL_RESET;
            st.ax[i].vector_member <= 1'b0;
         end
         st.target <= '0;
         st.target_vector <= 1'b0;
         st.ctrl <= 8'h00;
         st.src <= vso_pkg::SRC_IMMEDIATE;
         st.src_err <= 1'b0;
         st.rsp <= '0;
         st.vel_out <= '0;
         st.dir <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o = st.rsp.prdata;
   assign pready_o = st.rsp.pready;
   assign pslverr_o = st.rsp.pslverr;
   assign cur_vel_o = st.vel_out;
   assign dir_o = st.dir;
endmodule

/* File: hdl/vso_pkg.sv */
/*
 velocity setpoint and override package: register offsets, reset values,
 field layouts and carrier structs. assumes a 32-bit apb slave in front.
*/
package vso_pkg;
   localparam int NUM_AXES = 4;
   localparam int AX_W = 2;
   // register byte offsets
   localparam logic [7:0] OFF_VEL = 8'h00;
   localparam logic [7:0] OFF_ACC = 8'h04;
   localparam logic [7:0] OFF_DEC = 8'h08;
   localparam logic [7:0] OFF_SCURVE = 8'h0c;
   localparam logic [7:0] OFF_OVR = 8'h10;
   localparam logic [7:0] OFF_TARGET = 8'h14;
   localparam logic [7:0] OFF_CTRL = 8'h18;
   localparam logic [7:0] OFF_CMD = 8'h1c;
   localparam logic [7:0] OFF_SRC = 8'h20;
   localparam logic [7:0] OFF_ACT_VEL = 8'h24;
   localparam logic [7:0] OFF_CUR_VEL = 8'h28;
   localparam logic [7:0] OFF_STATUS = 8'h2c;
   // target register fields
   localparam int TGT_VECTOR_BIT = 8;
   // ctrl register fields
   localparam int CTRL_VELMODE_BIT = 0;
   localparam int CTRL_CONTOUR_BIT = 1;
   localparam int CTRL_GEAR_BIT = 2;
   localparam int CTRL_GEAR_MASTER_LSB = 4;
   // cmd register fields
   localparam int CMD_START_BIT = 0;
   localparam int CMD_BLEND_BIT = 1;
   localparam int CMD_TICK_BIT = 2;
   // override encoding: 256 is 100 percent, 384 is 150 percent
   localparam logic [8:0] OVR_NEUTRAL = 9'h100;
   localparam logic [8:0] OVR_MAX = 9'h180;
   localparam int OVR_SHIFT = 8;
   // source selector codes
   localparam logic [7:0] SRC_IMMEDIATE = 8'hff;
   localparam logic [7:0] SRC_VAR_LO = 8'h01;
   localparam logic [7:0] SRC_VAR_HI = 8'h78;
   localparam logic [7:0] SRC_IND_LO = 8'h81;
   localparam logic [7:0] SRC_IND_HI = 8'hf8;
   localparam logic [1:0] SRC_KIND_IMM = 2'h0;
   localparam logic [1:0] SRC_KIND_VAR = 2'h1;
   localparam logic [1:0] SRC_KIND_IND = 2'h2;
   localparam logic [1:0] SRC_KIND_BAD = 2'h3;
   // reset values
   localparam logic [31:0] VEL_RESET = 32'h0000_0000;
   localparam logic [31:0] ACC_RESET = 32'h0000_0100;
   localparam logic [15:0] SCURVE_RESET = 16'h0001;

   typedef struct packed {
      logic [31:0] vel_shadow;
      logic [31:0] vel_active;
      logic [31:0] acc;
      logic [31:0] dec;
      logic [15:0] scurve;
      logic [15:0] s_cnt;
      logic [8:0] ovr;
      logic [31:0] cur_vel;
      logic vector_member;
   } axis_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;
endpackage

/* File: tb/vso_props.sv */
/* port assertions for the velocity setpoint and override block.
   assumes one clock and an apb slave with one wait state. */
`timescale 1ns/1ps
module vso_props (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // trajectory
   input wire logic [vso_pkg::NUM_AXES*32-1:0] cur_vel_o,
   input wire logic [vso_pkg::NUM_AXES-1:0] dir_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic take;
   logic ovr_wr;
   assign take = psel_i && penable_i && !pready_o;
   assign ovr_wr = take && pwrite_i && paddr_i == vso_pkg::OFF_OVR;
   chk_ready_next: assert property (take |=> pready_o)
      else $error("access not answered");
   chk_ready_cause: assert property (pready_o |-> $past(take))
      else $error("answer without access");
   chk_ovr_refuse: assert property (ovr_wr && pwdata_i > 32'h0000_0180 |=> pslverr_o)
      else $error("override above range accepted");
   chk_ovr_accept: assert property (ovr_wr && pwdata_i <= 32'h0000_0180 |=> !pslverr_o)
      else $error("override in range refused");
   chk_ovr_no_step: assert property (ovr_wr |=> $stable(cur_vel_o))
      else $error("override stepped velocity");
   chk_vel_moves: assert property ($changed(cur_vel_o) |->
      pready_o && $past(pwrite_i && paddr_i == vso_pkg::OFF_CMD))
      else $error("velocity moved without tick");
   chk_dir_moves: assert property ($changed(dir_o) |-> pready_o && $past(pwrite_i &&
      (paddr_i == vso_pkg::OFF_CMD || paddr_i == vso_pkg::OFF_CTRL)))
      else $error("direction moved without command");
   chk_reset_clear: assert property ($fell(reset_i) |->
      cur_vel_o == '0 && dir_o == '0 && !pready_o)
      else $error("outputs not cleared by reset");
endmodule
bind velocity_setpoint_override vso_props u_props (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .cur_vel_o(cur_vel_o), .dir_o(dir_o));

/* File: tb/host_model.sv */
/* host model: apb master issuing motion parameter loads.
   assumes the slave answers with pready on the clock core_clk_i. */
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic core_clk_i,
   // apb response
   input wire logic [31:0] prdata_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   // apb request
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o
);
   logic hung = 1'b0;
   initial {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
   // fixed point and source codes come from the caller, whole words reloaded each time
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge core_clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= a;
      pwdata_o <= d;
      @(posedge core_clk_i);
      penable_o <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready_i !== 1'b1 && n < 20);
      hung = (n >= 20);
      r = prdata_i;
      e = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // released lines show stale inverse, not the last value
      paddr_o <= ~a;
      pwdata_o <= ~d;
   endtask
endmodule

/* File: tb/tb.sv */
/* testbench for velocity_setpoint_override: apb loads, ticks, checks.
   assumes host_model drives the bus and vso_props is bound. */
`timescale 1ns/1ps
module tb;
   logic core_clk_i, reset_i, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [vso_pkg::NUM_AXES*32-1:0] cur_vel;
   logic [vso_pkg::NUM_AXES-1:0] dir;
   logic [7:0] codes [7] = '{8'hff, 8'h01, 8'h78, 8'h81, 8'hf8, 8'h00, 8'h80};
   logic [1:0] kinds [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
   int bad_count = 0;
   int num_checks = 0;
   velocity_setpoint_override dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cur_vel_o(cur_vel), .dir_o(dir));
   host_model host (.core_clk_i(core_clk_i), .prdata_i(prdata), .pready_i(pready),
      .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
      .paddr_o(paddr), .pwdata_o(pwdata));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd, err);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0000_0000, rd, err);
      check(rd, exp);
   endtask
   // a tick is one sample period; the velocity is looked at after the last
   task automatic tick(input int n, input logic [31:0] exp);
      repeat (n) wr(vso_pkg::OFF_CMD, 32'h0000_0004);
      check(cur_vel[31:0], exp);
   endtask
   always @(posedge core_clk_i) if (host.hung === 1'b1) begin
      bad_count++;
      final_report();
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      bad_count++;
      final_report();
   end
   initial begin
      reset_i = 1'b1;
      repeat (10) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd_chk(vso_pkg::OFF_OVR, 32'h0000_0100);
      $display("test done: reset");
      wr(vso_pkg::OFF_TARGET, 32'h0000_0000);
      wr(vso_pkg::OFF_ACC, 32'h0000_8000);
      wr(vso_pkg::OFF_DEC, 32'h0000_8000);
      wr(vso_pkg::OFF_VEL, 32'h0002_0000);
      rd_chk(vso_pkg::OFF_ACT_VEL, 32'h0000_0000);
      tick(1, 32'h0000_0000);
      wr(vso_pkg::OFF_CMD, 32'h0000_0001);
      rd_chk(vso_pkg::OFF_ACT_VEL, 32'h0002_0000);
      for (int k = 1; k <= 4; k++) tick(1, 32'(k * 32'h0000_8000));
      tick(2, 32'h0002_0000);
      $display("test done: setpoint");
      wr(vso_pkg::OFF_OVR, 32'h0000_0080);
      tick(1, 32'h0001_8000);
      tick(1, 32'h0001_0000);
      wr(vso_pkg::OFF_OVR, 32'h0000_0000);
      tick(1, 32'h0000_8000);
      tick(1, 32'h0000_0000);
      wr(vso_pkg::OFF_OVR, 32'h0000_0181);
      check(32'(err), 32'h0000_0001);
      rd_chk(vso_pkg::OFF_OVR, 32'h0000_0000);
      wr(vso_pkg::OFF_OVR, 32'h0000_0180);
      tick(6, 32'h0003_0000);
      wr(vso_pkg::OFF_VEL, 32'h0001_0001);
      wr(vso_pkg::OFF_CMD, 32'h0000_0001);
      wr(vso_pkg::OFF_OVR, 32'h0000_00ff);
      tick(5, 32'h0000_ff00);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0001);
      wr(vso_pkg::OFF_VEL, 32'hffff_0000);
      wr(vso_pkg::OFF_CTRL, 32'h0000_0001);
      wr(vso_pkg::OFF_CMD, 32'h0000_0002);
      wr(vso_pkg::OFF_CMD, 32'h0000_0004);
      check(32'(dir), 32'h0000_0002);
      $display("test done: override");
      for (int i = 0; i < 7; i++) begin
         wr(vso_pkg::OFF_SRC, {24'h00_0000, codes[i]});
         host.xfer(1'b0, vso_pkg::OFF_STATUS, 32'h0000_0000, rd, err);
         check(32'(rd[2:0]), 32'({kinds[i] == 2'h3, kinds[i]}));
      end
      host.xfer(1'b1, 8'hfc, 32'h0000_0000, rd, err);
      check(32'(err), 32'h0000_0001);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0202);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0203);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0100);
      wr(vso_pkg::OFF_OVR, 32'h0000_00c8);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0203);
      wr(vso_pkg::OFF_OVR, 32'h0000_0064);
      check(32'(err), 32'h0000_0000);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0202);
      rd_chk(vso_pkg::OFF_OVR, 32'h0000_00c8);
      wr(vso_pkg::OFF_TARGET, 32'h0000_0000);
      rd_chk(vso_pkg::OFF_OVR, 32'h0000_00ff);
      $display("test done: codes and vector");
      wr(vso_pkg::OFF_CTRL, 32'h0000_0003);
      tick(1, 32'h0001_0001);
      wr(vso_pkg::OFF_ACC, 32'h0010_0000);
      wr(vso_pkg::OFF_DEC, 32'h0010_0000);
      wr(vso_pkg::OFF_CTRL, 32'h0000_0014);
      tick(1, 32'hffff_fe00);
      $display("test done: contour and gearing");
      final_report();
   end
endmodule
